// file: scsi_bus_if.sv
`timescale 1ns/1ps
// ============================================================
// wired-or bus: a line is true while any end enables its driver
interface scsi_bus_if;
  logic       t_bsy_oe;
  logic       t_sel_oe;
  logic       t_req_oe;
  logic       t_cd_oe;
  logic       t_io_oe;
  logic       t_msg_oe;
  logic [8:0] t_db_o;
  logic       t_db_oe;
  logic       i_bsy_oe;
  logic       i_ack_oe;
  logic       i_atn_oe;
  logic       i_rst_oe;
  logic [8:0] i_db_o;
  logic       i_db_oe;
  logic       bsy;
  logic       sel;
  logic       req;
  logic       ack;
  logic       atn;
  logic       rst;
  logic       cd;
  logic       io;
  logic       msg;
  logic [8:0] db;

  assign bsy = t_bsy_oe | i_bsy_oe;
  assign sel = t_sel_oe;
  assign req = t_req_oe;
  assign ack = i_ack_oe;
  assign atn = i_atn_oe;
  assign rst = i_rst_oe;
  assign cd  = t_cd_oe;
  assign io  = t_io_oe;
  assign msg = t_msg_oe;
  assign db  = (t_db_oe ? t_db_o : 9'h000) | (i_db_oe ? i_db_o : 9'h000);

  modport target (
    output t_bsy_oe, t_sel_oe, t_req_oe, t_cd_oe, t_io_oe, t_msg_oe,
    output t_db_o, t_db_oe,
    input  bsy, sel, ack, atn, rst, db
  );
  modport initiator (
    output i_bsy_oe, i_ack_oe, i_atn_oe, i_rst_oe, i_db_o, i_db_oe,
    input  bsy, sel, req, cd, io, msg, rst, db
  );
endinterface

// file: scsi_initiator_end.sv
`timescale 1ns/1ps
`include "scsi_link_map.svh"

module scsi_initiator_end
  import scsi_link_pkg::*;
#(
  parameter logic [2:0] OWN_ID = 3'h0
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  scsi_bus_if.initiator   bus,
  input  wire logic       atn_req,
  input  wire logic       bus_rst_req,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic [2:0]      phase,
  output logic            connected,
  output logic            resel_seen,
  input  wire logic       neg_load,
  input  wire logic       neg_sync,
  input  wire logic [7:0] neg_period
);

  // ============================================================
  // pin synchronisers
  logic [15:0]  s1_r;
  logic [15:0]  s2_r;
  logic         req_d_r;
  ini_regs_type r;
  ini_regs_type n;
  logic [8:0]   db_s;
  logic         req_s;
  logic         io_s;
  logic         cd_s;
  logic         msg_s;
  logic         bsy_s;
  logic         sel_s;
  logic         rst_s;
  logic         req_rise;
  logic         sph;
  logic         inc;
  logic         dec;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_r    <= 16'h0000;
      s2_r    <= 16'h0000;
      req_d_r <= 1'b0;
    end else begin
      s1_r    <= {bus.rst, bus.sel, bus.bsy, bus.msg, bus.cd, bus.io,
                  bus.req, bus.db};
      s2_r    <= s1_r;
      req_d_r <= req_s;
    end
  end

  assign db_s     = s2_r[8:0];
  assign req_s    = s2_r[9];
  assign io_s     = s2_r[10];
  assign cd_s     = s2_r[11];
  assign msg_s    = s2_r[12];
  assign bsy_s    = s2_r[13];
  assign sel_s    = s2_r[14];
  assign rst_s    = s2_r[15];
  assign req_rise = req_s & ~req_d_r;
  assign sph      = r.syn & ~cd_s & ~msg_s;

  // ============================================================
  // handshake engine
  always_comb begin
    n     = r;
    n.tmr = (r.tmr != 8'h00) ? r.tmr - 8'h01 : 8'h00;
    n.per = (r.per != 8'h00) ? r.per - 8'h01 : 8'h00;
    n.txr  = 1'b0;
    n.rxv  = 1'b0;
    n.rsel = 1'b0;
    n.ph   = {msg_s, cd_s, io_s};
    n.atn  = atn_req;
    n.rstd = bus_rst_req;
    inc = sph & req_rise;
    dec = 1'b0;
    if (neg_load) begin
      n.syn = neg_sync;
      n.prd = neg_period;
    end
    // sync in sampled at req rise
    if (inc & io_s) begin
      n.rxd = db_s[7:0];
      n.rxv = 1'b1;
    end
    unique case (r.st)
      I_IDLE: begin
        if (sel_s & io_s & ~bsy_s & db_s[OWN_ID]) begin
          n.bsy  = 1'b1;
          n.rsel = 1'b1;
          n.st   = I_RESEL;
        end
      end
      I_RESEL: begin
        if (!sel_s) begin
          n.bsy  = 1'b0;
          n.conn = 1'b1;
          n.st   = I_CONN;
        end
      end
      I_CONN: begin
        if (!bsy_s) begin
          n.conn = 1'b0;
          n.st   = I_IDLE;
        end else if (sph) begin
          if (r.pend != 4'h0 && r.tmr == 8'h00 && r.per == 8'h00) begin
            if (io_s) begin
              n.ack = 1'b1;
              n.tmr = 8'(`CYC_REQ_HI);
              n.per = r.prd;
              dec   = 1'b1;
              n.st  = I_SACK;
            end else if (tx_valid) begin
              n.dbo  = {~^tx_data, tx_data};
              n.dboe = 1'b1;
              n.txr  = 1'b1;
              n.tmr  = 8'(`CYC(`T_SETUP_NS));
              n.st   = I_ODS;
            end
          end
        end else if (req_s) begin
          if (io_s) begin
            n.rxd = db_s[7:0];
            n.rxv = 1'b1;
            n.ack = 1'b1;
            n.st  = I_WREQLO;
          end else if (tx_valid) begin
            n.dbo  = {~^tx_data, tx_data};
            n.dboe = 1'b1;
            n.txr  = 1'b1;
            n.tmr  = 8'(`CYC(`T_SETUP_NS));
            n.st   = I_ODS;
          end
        end
      end
      I_ODS: begin
        if (r.tmr == 8'h00) begin
          n.ack = 1'b1;
          if (sph) begin
            n.tmr = 8'(`CYC_REQ_HI);
            n.per = r.prd;
            dec   = 1'b1;
            n.st  = I_SACK;
          end else begin
            n.st = I_WREQLO;
          end
        end
      end
      I_WREQLO: begin
        if (!req_s) begin
          n.ack  = 1'b0;
          n.dboe = 1'b0;
          n.st   = I_CONN;
        end
      end
      I_SACK: begin
        if (r.tmr == 8'h00) begin
          n.ack  = 1'b0;
          n.dboe = 1'b0;
          n.tmr  = 8'(`CYC(`T_NEGATE_NS));
          n.st   = I_CONN;
        end
      end
    endcase
    n.pend = r.pend + {3'h0, inc} - {3'h0, dec};
    if (rst_s) begin
      n.st   = I_IDLE;
      n.bsy  = 1'b0;
      n.ack  = 1'b0;
      n.dboe = 1'b0;
      n.syn  = 1'b0;
      n.conn = 1'b0;
      n.pend = 4'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r    <= '0;
      r.st <= I_IDLE;
    end else begin
      r <= n;
    end
  end

  assign bus.i_bsy_oe = r.bsy;
  assign bus.i_ack_oe = r.ack;
  assign bus.i_atn_oe = r.atn;
  assign bus.i_rst_oe = r.rstd;
  assign bus.i_db_o   = r.dbo;
  assign bus.i_db_oe  = r.dboe;
  assign tx_ready     = r.txr;
  assign rx_data      = r.rxd;
  assign rx_valid     = r.rxv;
  assign phase        = r.ph;
  assign connected    = r.conn;
  assign resel_seen   = r.rsel;

endmodule

// file: scsi_link_assertions.sv
`timescale 1ns/1ps
module scsi_link_assertions #(
  parameter int MAX_OUT = 2
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       t_bsy_oe,
  input wire logic       i_bsy_oe,
  input wire logic       bsy,
  input wire logic       sel,
  input wire logic       req,
  input wire logic       ack,
  input wire logic       cd,
  input wire logic       io,
  input wire logic       msg,
  input wire logic [8:0] t_db_o,
  input wire logic [8:0] db
);
  logic [2:0] ph_r;
  logic [5:0] age_r;
  logic [5:0] age_nxt;
  logic [3:0] pend_r;
  logic [3:0] pend_nxt;
  logic       req_r;
  logic       ack_r;

  // cycles the phase lines have been steady; req/ack pulses in flight
  always_comb begin
    age_nxt = age_r + {5'h00, age_r != 6'h3F};
    if ({cd, io, msg} != ph_r)
      age_nxt = 6'h00;
    pend_nxt = pend_r + {3'h0, req & ~req_r} - {3'h0, ack & ~ack_r};
    if (!bsy)
      pend_nxt = 4'h0;
  end

  always_ff @(posedge mclk) begin
    ph_r   <= rst ? 3'h0 : {cd, io, msg};
    age_r  <= rst ? 6'h00 : age_nxt;
    pend_r <= rst ? 4'h0 : pend_nxt;
    req_r  <= rst ? 1'b0 : req;
    ack_r  <= rst ? 1'b0 : ack;
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_init_reply;
    sel && i_bsy_oe && !t_bsy_oe;
  endsequence
  sequence s_tgt_join;
    ##[1:8] t_bsy_oe;
  endsequence

  a_resel_ids: assert property ($rose(sel) |-> io && db[7]
    && $countones(db[7:0]) == 2) else $error("reselect ids wrong");
  a_bsy_reply: assert property (s_init_reply |-> s_tgt_join)
    else $error("target did not rejoin busy");
  a_sel_drop: assert property ($fell(sel) && i_bsy_oe |-> t_bsy_oe)
    else $error("select dropped without busy");
  a_xfer_bsy: assert property (req |-> bsy && !sel)
    else $error("busy or select wrong in transfer");
  a_phase_hold: assert property ((req || ack) && $past(req || ack)
    |-> $stable({cd, io, msg})) else $error("phase moved in handshake");
  a_phase_settle: assert property ($rose(req) |-> age_r >= 6'h12)
    else $error("request before settle");
  a_data_setup: assert property ($rose(req) && io
    |-> $past(t_db_o, 3) == t_db_o) else $error("data setup short");
  a_data_hold: assert property (req && io && $past(req)
    |-> $stable(t_db_o)) else $error("data moved under request");
  a_async_neg: assert property ($fell(req) && (cd || msg)
    |-> $past(ack)) else $error("request dropped before ack");
  a_req_width: assert property ($rose(req) |-> req[*5])
    else $error("request pulse short");
  a_req_gap: assert property ($fell(req) |-> !req[*5])
    else $error("request gap short");
  a_offset_cap: assert property (pend_r <= MAX_OUT)
    else $error("offset exceeded");
  a_free_lines: assert property (!bsy && !sel
    |-> !req && !cd && !io && !msg) else $error("line held in bus free");
endmodule

// file: scsi_link_map.svh
`ifndef SCSI_LINK_MAP_SVH
`define SCSI_LINK_MAP_SVH

// ============================================================
// clock and bus delays
`define CLK_NS          20
`define CYC(ns)         (((ns) + `CLK_NS - 1) / `CLK_NS)
`define T_ARB_NS        2200
`define T_BUS_FREE_NS   800
`define T_SETTLE_NS     400
`define T_DESKEW_NS     45
`define T_SKEW_NS       10
`define T_HOLD_NS       45
`define T_ASSERT_NS     90
`define T_NEGATE_NS     90
`define T_SELTO_MS      250
`define T_SETUP_NS      (`T_DESKEW_NS + `T_SKEW_NS)
`define T_SHOLD_NS      (`T_SETUP_NS + `T_HOLD_NS)
`define CYC_REQ_HI      ((`CYC(`T_ASSERT_NS) > `CYC(`T_SHOLD_NS)) ? \
                         `CYC(`T_ASSERT_NS) : `CYC(`T_SHOLD_NS))
`define SELTO_CYC       ((`T_SELTO_MS * 1000000) / `CLK_NS)
`define SYNC_GUARD      8'h04

// ============================================================
// counts, codes and phase bit positions
`define RESEL_RETRIES   255
`define MSG_IDENTIFY    8'h80
`define PH_IO           0
`define PH_CD           1
`define PH_MSG          2
`define PH_MSG_IN       3'h7

`endif

// file: scsi_link_pkg.sv
package scsi_link_pkg;

  typedef logic [23:0] tmr_type;

  typedef enum logic [12:0] {
    T_IDLE   = 13'h0001,
    T_FREEWT = 13'h0002,
    T_ARB    = 13'h0004,
    T_RESEL  = 13'h0008,
    T_RSACK  = 13'h0010,
    T_CONN   = 13'h0020,
    T_SETTLE = 13'h0040,
    T_LOAD   = 13'h0080,
    T_DESKEW = 13'h0100,
    T_REQ    = 13'h0200,
    T_ACKHI  = 13'h0400,
    T_ACKLO  = 13'h0800,
    T_NEG    = 13'h1000
  } tgt_state_type;

  typedef struct packed {
    tgt_state_type st;
    tmr_type       tmr;
    logic [7:0]    per;
    logic [3:0]    outc;
    logic [15:0]   left;
    logic [7:0]    retry;
    logic [2:0]    ph;
    logic          bsy;
    logic          sel;
    logic          req;
    logic [8:0]    dbo;
    logic          dboe;
    logic          ident;
    logic          sph;
    logic          syn;
    logic [3:0]    off;
    logic [7:0]    prd;
    logic          txr;
    logic [7:0]    rxd;
    logic          rxv;
    logic          done;
    logic          conn;
    logic          fail;
    logic          rsts;
    logic          atn;
  } tgt_regs_type;

  typedef enum logic [5:0] {
    I_IDLE   = 6'h01,
    I_RESEL  = 6'h02,
    I_CONN   = 6'h04,
    I_ODS    = 6'h08,
    I_WREQLO = 6'h10,
    I_SACK   = 6'h20
  } ini_state_type;

  typedef struct packed {
    ini_state_type st;
    logic [7:0]    tmr;
    logic [7:0]    per;
    logic [3:0]    pend;
    logic          bsy;
    logic          ack;
    logic          atn;
    logic          rstd;
    logic [8:0]    dbo;
    logic          dboe;
    logic          syn;
    logic [7:0]    prd;
    logic          txr;
    logic [7:0]    rxd;
    logic          rxv;
    logic          conn;
    logic          rsel;
    logic [2:0]    ph;
  } ini_regs_type;

endpackage

// file: scsi_target_end.sv
`timescale 1ns/1ps
`include "scsi_link_map.svh"

// Contract
// - arbitrate, then reselect with both ids
// - initiator asserts bsy, releases after sel
// - release bsy, reassert on reply, drop sel
// - identify message follows reselection
// - selection timeout retries up to limit
// - no disconnect without initiator identity
// - target alone drives phase lines
// - initiator requests message out via atn
// - bus free releases every driven line
// - one byte per handshake, bsy held
// - phase lines settle before first req
// - async in: data, deskew, req, ack
// - initiator acks, then waits req low
// - async out: req, sample on ack
// - initiator drives data before ack
// - sync agreement kept until reset
// - req held off at offset limit
// - sync phase ends with counts equal
// - sync req assertion and spacing times
// - initiator returns one ack per req
// - sync in data held past req
// - sync out sampled at ack rise
module scsi_target_end
  import scsi_link_pkg::*;
#(
  parameter logic [2:0] OWN_ID    = 3'h7,
  parameter int         SELTO_CYC = `SELTO_CYC,
  parameter int         RETRY_MAX = `RESEL_RETRIES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  scsi_bus_if.target       bus,
  input  wire logic        resel_start,
  input  wire logic [2:0]  init_id,
  input  wire logic [2:0]  lun,
  input  wire logic        phase_start,
  input  wire logic [2:0]  phase_sel,
  input  wire logic [15:0] byte_count,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic [7:0]       rx_data,
  output logic             rx_valid,
  output logic             phase_done,
  input  wire logic        free_req,
  input  wire logic        free_disc,
  input  wire logic        disc_ok,
  input  wire logic        neg_load,
  input  wire logic [3:0]  neg_offset,
  input  wire logic [7:0]  neg_period,
  output logic             connected,
  output logic             resel_fail,
  output logic             bus_reset_seen,
  output logic             attention
);

  localparam logic [7:0] ID_BIT  = 8'h01 << OWN_ID;
  localparam logic [7:0] HI_MASK = ~((ID_BIT << 1) - 8'h01);

  // ============================================================
  // pin synchronisers
  logic [13:0]  s1_r;
  logic [13:0]  s2_r;
  logic         ack_d_r;
  tgt_regs_type r;
  tgt_regs_type n;
  logic [8:0]   db_s;
  logic         bsy_s;
  logic         sel_s;
  logic         ack_s;
  logic         atn_s;
  logic         rst_s;
  logic         ack_rise;
  logic         inc;
  logic         dec;
  logic [7:0]   id_byte;

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_r    <= 14'h0000;
      s2_r    <= 14'h0000;
      ack_d_r <= 1'b0;
    end else begin
      s1_r    <= {bus.rst, bus.atn, bus.ack, bus.sel, bus.bsy, bus.db};
      s2_r    <= s1_r;
      ack_d_r <= ack_s;
    end
  end

  assign db_s     = s2_r[8:0];
  assign bsy_s    = s2_r[9];
  assign sel_s    = s2_r[10];
  assign ack_s    = s2_r[11];
  assign atn_s    = s2_r[12];
  assign rst_s    = s2_r[13];
  assign ack_rise = ack_s & ~ack_d_r;
  assign id_byte  = `MSG_IDENTIFY | {5'h00, lun};

  // ============================================================
  // connection and transfer sequencer
  always_comb begin
    n     = r;
    n.tmr = (r.tmr != '0) ? r.tmr - tmr_type'(1) : '0;
    n.per = (r.per != 8'h00) ? r.per - 8'h01 : 8'h00;
    n.txr  = 1'b0;
    n.rxv  = 1'b0;
    n.done = 1'b0;
    n.fail = 1'b0;
    n.rsts = 1'b0;
    n.atn  = atn_s;
    inc = 1'b0;
    dec = r.sph & ack_rise;
    if (neg_load) begin
      n.syn = (neg_offset != 4'h0);
      n.off = neg_offset;
      n.prd = neg_period;
    end
    // sync out byte taken at ack rise
    if (dec & ~r.ph[`PH_IO]) begin
      n.rxd = db_s[7:0];
      n.rxv = 1'b1;
    end
    unique case (r.st)
      T_IDLE: begin
        if (resel_start) begin
          n.retry = 8'h00;
          n.tmr   = tmr_type'(`CYC(`T_BUS_FREE_NS));
          n.st    = T_FREEWT;
        end
      end
      T_FREEWT: begin
        // arbitrate once the bus is free
        if (bsy_s | sel_s) begin
          n.tmr = tmr_type'(`CYC(`T_BUS_FREE_NS));
        end else if (r.tmr == '0) begin
          n.bsy  = 1'b1;
          n.dbo  = {1'b0, ID_BIT};
          n.dboe = 1'b1;
          n.tmr  = tmr_type'(`CYC(`T_ARB_NS));
          n.st   = T_ARB;
        end
      end
      T_ARB: begin
        if (r.tmr == '0) begin
          if ((db_s[7:0] & HI_MASK) != 8'h00 || sel_s) begin
            n.bsy  = 1'b0;
            n.dboe = 1'b0;
            n.tmr  = tmr_type'(`CYC(`T_BUS_FREE_NS));
            n.st   = T_FREEWT;
          end else begin
            n.sel         = 1'b1;
            n.dbo[7:0]    = ID_BIT | (8'h01 << init_id);
            n.dbo[8]      = ~^(ID_BIT | (8'h01 << init_id));
            n.ph[`PH_IO]  = 1'b1;
            n.tmr         = tmr_type'(`CYC(`T_SETTLE_NS));
            n.st          = T_RESEL;
          end
        end
      end
      T_RESEL: begin
        if (r.bsy) begin
          if (r.tmr == '0) begin
            n.bsy = 1'b0;
            n.tmr = tmr_type'(SELTO_CYC);
            n.per = `SYNC_GUARD;
          end
        end else if (bsy_s && r.per == 8'h00) begin
          n.bsy = 1'b1;
          n.tmr = tmr_type'(`CYC(`T_SETTLE_NS));
          n.st  = T_RSACK;
        end else if (r.tmr == '0) begin
          n.sel  = 1'b0;
          n.dboe = 1'b0;
          n.ph   = 3'h0;
          if (r.retry == 8'(RETRY_MAX)) begin
            n.fail = 1'b1;
            n.st   = T_IDLE;
          end else begin
            n.retry = r.retry + 8'h01;
            n.tmr   = tmr_type'(`CYC(`T_BUS_FREE_NS));
            n.st    = T_FREEWT;
          end
        end
      end
      T_RSACK: begin
        if (r.tmr == '0) begin
          n.sel   = 1'b0;
          n.dboe  = 1'b0;
          n.conn  = 1'b1;
          n.ident = 1'b1;
          n.left  = 16'h0001;
          n.ph    = `PH_MSG_IN;
          n.sph   = 1'b0;
          n.outc  = 4'h0;
          n.tmr   = tmr_type'(`CYC(`T_SETTLE_NS));
          n.st    = T_SETTLE;
        end
      end
      T_CONN: begin
        if (free_req && (!free_disc || disc_ok)) begin
          n.bsy  = 1'b0;
          n.ph   = 3'h0;
          n.dboe = 1'b0;
          n.conn = 1'b0;
          n.st   = T_IDLE;
        end else if (phase_start) begin
          n.ph    = phase_sel;
          n.left  = byte_count;
          n.ident = 1'b0;
          n.sph   = r.syn & ~phase_sel[`PH_CD] & ~phase_sel[`PH_MSG];
          n.outc  = 4'h0;
          n.tmr   = tmr_type'(`CYC(`T_SETTLE_NS));
          n.st    = T_SETTLE;
        end
      end
      T_SETTLE: begin
        if (r.tmr == '0) begin
          if (r.left == 16'h0000) begin
            n.done = 1'b1;
            n.st   = T_CONN;
          end else begin
            n.st = r.ph[`PH_IO] ? T_LOAD : T_DESKEW;
          end
        end
      end
      T_LOAD: begin
        if (r.ident || tx_valid) begin
          n.dbo  = r.ident ? {~^id_byte, id_byte} : {~^tx_data, tx_data};
          n.txr  = ~r.ident;
          n.dboe = 1'b1;
          n.tmr  = tmr_type'(`CYC(`T_SETUP_NS));
          n.st   = T_DESKEW;
        end
      end
      T_DESKEW: begin
        if (r.tmr == '0 && r.per == 8'h00 && (!r.sph || r.outc < r.off)) begin
          n.req  = 1'b1;
          n.left = r.left - 16'h0001;
          if (r.sph) begin
            inc   = 1'b1;
            n.tmr = tmr_type'(`CYC_REQ_HI);
            n.per = r.prd;
            n.st  = T_REQ;
          end else begin
            n.st = T_ACKHI;
          end
        end
      end
      T_REQ: begin
        if (r.tmr == '0) begin
          n.req = 1'b0;
          n.tmr = tmr_type'(`CYC(`T_NEGATE_NS));
          n.st  = T_NEG;
        end
      end
      T_NEG: begin
        if (r.tmr == '0) begin
          if (r.left != 16'h0000) begin
            n.st = r.ph[`PH_IO] ? T_LOAD : T_DESKEW;
          end else if (r.outc == 4'h0 && !ack_s) begin
            n.done = 1'b1;
            n.dboe = 1'b0;
            n.st   = T_CONN;
          end
        end
      end
      T_ACKHI: begin
        // sample on ack, then drop req
        if (ack_s) begin
          if (!r.ph[`PH_IO]) begin
            n.rxd = db_s[7:0];
            n.rxv = 1'b1;
          end
          n.req = 1'b0;
          n.st  = T_ACKLO;
        end
      end
      T_ACKLO: begin
        if (!ack_s) begin
          if (r.left != 16'h0000) begin
            n.st = r.ph[`PH_IO] ? T_LOAD : T_DESKEW;
          end else begin
            n.done = 1'b1;
            n.dboe = 1'b0;
            n.st   = T_CONN;
          end
        end
      end
    endcase
    n.outc = r.outc + {3'h0, inc} - {3'h0, dec};
    if (rst_s) begin
      // bus reset returns to bus free
      n.st   = T_IDLE;
      n.bsy  = 1'b0;
      n.sel  = 1'b0;
      n.req  = 1'b0;
      n.ph   = 3'h0;
      n.dboe = 1'b0;
      n.conn = 1'b0;
      n.syn  = 1'b0;
      n.outc = 4'h0;
      n.rsts = ~r.rsts & (r.st != T_IDLE || r.syn);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      r    <= '0;
      r.st <= T_IDLE;
    end else begin
      r <= n;
    end
  end

  assign bus.t_bsy_oe  = r.bsy;
  assign bus.t_sel_oe  = r.sel;
  assign bus.t_req_oe  = r.req;
  assign bus.t_io_oe   = r.ph[`PH_IO];
  assign bus.t_cd_oe   = r.ph[`PH_CD];
  assign bus.t_msg_oe  = r.ph[`PH_MSG];
  assign bus.t_db_o    = r.dbo;
  assign bus.t_db_oe   = r.dboe;
  assign tx_ready       = r.txr;
  assign rx_data        = r.rxd;
  assign rx_valid       = r.rxv;
  assign phase_done     = r.done;
  assign connected      = r.conn;
  assign resel_fail     = r.fail;
  assign bus_reset_seen = r.rsts;
  assign attention      = r.atn;

endmodule

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        rs_go = 1'b0, ph_go = 1'b0, fr_go = 1'b0, fr_disc = 1'b0;
  logic        nl = 1'b0, atn_r = 1'b0, brst = 1'b0, tv = 1'b0, nsy = 1'b0;
  logic        t_rxv, t_done, t_conn, t_fail, t_brs, t_atn, i_rxv, i_conn;
  logic        t_txr, i_txr, i_rsl, dok = 1'b0;
  logic [7:0]  iper = 8'h00;
  logic [2:0]  iid = 3'h0, ps = 3'h0, i_ph;
  logic [3:0]  noff = 4'h0;
  logic [7:0]  txd = 8'h00, nper = 8'h00, t_rxd, i_rxd, t_last, i_last;
  logic [15:0] nb = 16'h0000;
  logic        sel_q = 1'b0;
  logic [10:0] rows [6] = '{11'h1A5, 11'h03C, 11'h212, 11'h302,
                            11'h75A, 11'h6C3};
  int          err_total = 0, checked = 0, cyc = 0;
  int          i_n = 0, t_n = 0, sel_n = 0, tx_n = 0, rs_n = 0, c0;

  scsi_bus_if bus ();

  scsi_target_end #(.SELTO_CYC(200), .RETRY_MAX(2)) u_scsi_target_end (
    .mclk(mclk), .rst(rst), .bus(bus), .resel_start(rs_go),
    .init_id(iid), .lun(3'h3), .phase_start(ph_go), .phase_sel(ps),
    .byte_count(nb), .tx_data(txd), .tx_valid(tv), .tx_ready(t_txr),
    .rx_data(t_rxd), .rx_valid(t_rxv), .phase_done(t_done),
    .free_req(fr_go), .free_disc(fr_disc), .disc_ok(dok),
    .neg_load(nl), .neg_offset(noff), .neg_period(nper),
    .connected(t_conn), .resel_fail(t_fail), .bus_reset_seen(t_brs),
    .attention(t_atn));

  scsi_initiator_end u_scsi_initiator_end (
    .mclk(mclk), .rst(rst), .bus(bus), .atn_req(atn_r),
    .bus_rst_req(brst), .tx_data(txd), .tx_valid(tv), .tx_ready(i_txr),
    .rx_data(i_rxd), .rx_valid(i_rxv), .phase(i_ph),
    .connected(i_conn), .resel_seen(i_rsl), .neg_load(nl),
    .neg_sync(nsy), .neg_period(iper));

  scsi_link_assertions #(.MAX_OUT(2)) u_chk (
    .mclk(mclk), .rst(rst), .t_bsy_oe(bus.t_bsy_oe),
    .i_bsy_oe(bus.i_bsy_oe), .bsy(bus.bsy), .sel(bus.sel), .req(bus.req),
    .ack(bus.ack), .cd(bus.cd), .io(bus.io), .msg(bus.msg),
    .t_db_o(bus.t_db_o), .db(bus.db));

  always #10 mclk = ~mclk;

  // ==========================================================
  // receive capture, reselect attempts and run ceiling
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    sel_q <= bus.sel;
    if (bus.sel && !sel_q)
      sel_n <= sel_n + 1;
    tx_n <= tx_n + int'(t_txr === 1'b1) + int'(i_txr === 1'b1);
    if (i_rsl === 1'b1)
      rs_n <= rs_n + 1;
    if (i_rxv === 1'b1) begin
      i_last <= i_rxd;
      i_n <= i_n + 1;
    end
    if (t_rxv === 1'b1) begin
      t_last <= t_rxd;
      t_n <= t_n + 1;
    end
    if (cyc == 30000) begin
      err_total = err_total + 1;
      end_of_test();
    end
  end

  task end_of_test;
    if (err_total == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task go_phase(input logic [2:0] s, input logic [15:0] n);
    ps = s;
    nb = n;
    ph_go = 1'b1;
    tick(1);
    ph_go = 1'b0;
    do tick(1); while (t_done !== 1'b1);
    tick(8);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    tick(4);
    rst = 1'b0;
    tv = 1'b1;
    rs_go = 1'b1;
    tick(1);
    rs_go = 1'b0;
    do tick(1); while (t_done !== 1'b1);
    tick(8);
    chk("identify", i_last, 8'h83);
    chk("connected", {7'h00, t_conn}, 8'h01);
    chk("phase", {5'h00, i_ph}, 8'h07);
    foreach (rows[k]) begin
      txd = rows[k][7:0];
      go_phase(rows[k][10:8], 16'h0002);
      chk("phase", {5'h00, i_ph}, {5'h00, rows[k][10:8]});
      chk("byte", rows[k][8] ? i_last : t_last, rows[k][7:0]);
    end
    noff = 4'h2;
    nper = 8'h08;
    // slower acks so the target reaches its offset limit
    iper = 8'h30;
    nsy = 1'b1;
    nl = 1'b1;
    tick(1);
    nl = 1'b0;
    for (int d = 1; d >= 0; d--) begin
      c0 = d ? i_n : t_n;
      txd = 8'h69;
      go_phase({2'b00, d[0]}, 16'h0006);
      chk("sync count", 8'(d ? i_n - c0 : t_n - c0), 8'h06);
      chk("sync byte", d ? i_last : t_last, 8'h69);
    end
    atn_r = 1'b1;
    tick(8);
    chk("attention", {7'h00, t_atn}, 8'h01);
    atn_r = 1'b0;
    fr_disc = 1'b1;
    fr_go = 1'b1;
    tick(1);
    fr_go = 1'b0;
    tick(10);
    chk("connected", {7'h00, t_conn}, 8'h01);
    dok = 1'b1;
    fr_go = 1'b1;
    tick(1);
    fr_go = 1'b0;
    tick(10);
    chk("connected", {7'h00, t_conn}, 8'h00);
    chk("busy", {7'h00, bus.bsy}, 8'h00);
    iid = 3'h3;
    c0 = sel_n;
    rs_go = 1'b1;
    tick(1);
    rs_go = 1'b0;
    do tick(1); while (t_fail !== 1'b1);
    chk("attempts", 8'(sel_n - c0), 8'h03);
    brst = 1'b1;
    do tick(1); while (t_brs !== 1'b1);
    brst = 1'b0;
    tick(2);
    chk("reset pulse", {7'h00, t_brs}, 8'h00);
    tick(6);
    chk("init conn", {7'h00, i_conn}, 8'h00);
    chk("bytes taken", 8'(tx_n), 8'h18);
    chk("resel seen", 8'(rs_n), 8'h01);
    end_of_test();
  end
endmodule
